/* File: pkg/ur_pkg.sv */
// Package for the UART register map decoder: offsets, field positions,
// reset values, the slot enumeration and the carrier structs.
// Assumes a single clock domain shared by the access port and the core.

package ur_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_HOLD = 4'h0;
    localparam logic [3:0] ADDR_IRQ_EN = 4'h1;
    localparam logic [3:0] ADDR_IRQ_SRC = 4'h2;
    localparam logic [3:0] ADDR_LINE_CTL = 4'h3;
    localparam logic [3:0] ADDR_MODEM_CTL = 4'h4;
    localparam logic [3:0] ADDR_LINE_ST = 4'h5;
    localparam logic [3:0] ADDR_MODEM_ST = 4'h6;
    localparam logic [3:0] ADDR_SCRATCH = 4'h7;
    localparam logic [3:0] ADDR_TX_FILL = 4'h8;
    localparam logic [3:0] ADDR_RX_FILL = 4'h9;
    localparam logic [3:0] ADDR_GPIO_DIR = 4'hA;
    localparam logic [3:0] ADDR_GPIO_STATE = 4'hB;
    localparam logic [3:0] ADDR_GPIO_IRQ = 4'hC;
    localparam logic [3:0] ADDR_RESERVED = 4'hD;
    localparam logic [3:0] ADDR_GPIO_CFG = 4'hE;
    localparam logic [3:0] ADDR_EXTRA = 4'hF;

    // ------------------------------------------------------------
    // Field positions and key values
    // ------------------------------------------------------------
    localparam logic [7:0] LC_ENH_KEY = 8'hBF;
    localparam int LC_DIV_BIT = 7;
    localparam int ENH_UNLOCK_BIT = 4;
    localparam int MC_ALT_BIT = 2;
    localparam int QC_ENABLE_BIT = 0;
    localparam int QC_RX_RESET_BIT = 1;
    localparam int QC_TX_RESET_BIT = 2;
    localparam logic [7:0] IE_LOCK_MASK = 8'hF0;
    localparam logic [7:0] QC_LOCK_MASK = 8'h30;
    localparam logic [7:0] MC_LOCK_MASK = 8'hE0;
    localparam logic [5:0] IS_LOCK_MASK = 6'h30;
    localparam logic [7:0] QC_STORE_MASK = 8'hF9;
    localparam logic [7:0] FILL_MASK = 8'h7F;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // ------------------------------------------------------------
    // Register slots, one-hot
    // ------------------------------------------------------------
    typedef enum logic [25:0] {
        S_NONE       = 26'h0000001,
        S_HOLD       = 26'h0000002,
        S_DIV_LO     = 26'h0000004,
        S_DIV_HI     = 26'h0000008,
        S_DIV_FRAC   = 26'h0000010,
        S_IRQ_EN     = 26'h0000020,
        S_IRQ_SRC    = 26'h0000040,
        S_LINE_CTL   = 26'h0000080,
        S_MODEM_CTL  = 26'h0000100,
        S_LINE_ST    = 26'h0000200,
        S_MODEM_ST   = 26'h0000400,
        S_SCRATCH    = 26'h0000800,
        S_FLOW_LVL   = 26'h0001000,
        S_TRIG_LVL   = 26'h0002000,
        S_TX_FILL    = 26'h0004000,
        S_RX_FILL    = 26'h0008000,
        S_GPIO_DIR   = 26'h0010000,
        S_GPIO_STATE = 26'h0020000,
        S_GPIO_IRQ   = 26'h0040000,
        S_GPIO_CFG   = 26'h0080000,
        S_EXTRA      = 26'h0100000,
        S_ENH        = 26'h0200000,
        S_XON1       = 26'h0400000,
        S_XON2       = 26'h0800000,
        S_XOFF1      = 26'h1000000,
        S_XOFF2      = 26'h2000000
    } ur_slot_t;

    // ------------------------------------------------------------
    // Carrier structs
    // ------------------------------------------------------------
    typedef struct packed {
        logic rd;
        logic wr;
        logic [3:0] addr;
        logic [7:0] wdata;
    } ur_req_t;

    typedef struct packed {
        logic [7:0] rx_byte;
        logic [7:0] line_state;
        logic [7:0] modem_state;
        logic [5:0] irq_code;
        logic [6:0] tx_fill;
        logic [6:0] rx_fill;
    } ur_core_t;

    typedef struct packed {
        logic [7:0] div_lo;
        logic [7:0] div_hi;
        logic [7:0] div_frac;
        logic [7:0] irq_en;
        logic [7:0] queue_ctl;
        logic [7:0] line_ctl;
        logic [7:0] modem_ctl;
        logic [7:0] flow_lvl;
        logic [7:0] trig_lvl;
        logic [7:0] scratch;
        logic [7:0] xon1;
        logic [7:0] xon2;
        logic [7:0] xoff1;
        logic [7:0] xoff2;
        logic [7:0] gpio_dir;
        logic [7:0] gpio_out;
        logic [7:0] gpio_irq_en;
        logic [7:0] gpio_cfg;
        logic [7:0] extra;
        logic [7:0] enh;
    } ur_cfg_t;

endpackage : ur_pkg

/* File: src/ur_slot_decode.sv */
// Register page decoder: maps an address to one register slot.
// Assumes line control, unlock and alternate-table bits are current flops.

`timescale 1ns/1ps
`default_nettype none

module ur_slot_decode (
    input wire logic [3:0] addr,
    input wire logic [7:0] line_ctl,
    input wire logic enh_unlock,
    input wire logic alt_tables,
    output ur_pkg::ur_slot_t slot
);
    import ur_pkg::*;

    logic key_page;
    logic div_page;

    // Page flags, from the line control value in force this cycle
    assign key_page = (line_ctl == LC_ENH_KEY);
    assign div_page = line_ctl[LC_DIV_BIT] && !key_page;

    // ------------------------------------------------------------
    // Address to slot
    // ------------------------------------------------------------
    always_comb begin
        slot = S_NONE;
        unique case (addr)
            ADDR_HOLD: begin
                if (!line_ctl[LC_DIV_BIT]) slot = S_HOLD;
                else if (div_page) slot = S_DIV_LO;
            end
            ADDR_IRQ_EN: begin
                if (!line_ctl[LC_DIV_BIT]) slot = S_IRQ_EN;
                else if (div_page) slot = S_DIV_HI;
            end
            ADDR_IRQ_SRC: begin
                if (key_page) slot = S_ENH;
                else if (!line_ctl[LC_DIV_BIT]) slot = S_IRQ_SRC;
                else if (enh_unlock) slot = S_DIV_FRAC;
            end
            ADDR_LINE_CTL: slot = S_LINE_CTL;
            ADDR_MODEM_CTL: slot = key_page ? S_XON1 : S_MODEM_CTL;
            ADDR_LINE_ST: slot = key_page ? S_XON2 : S_LINE_ST;
            ADDR_MODEM_ST: begin
                if (key_page) slot = S_XOFF1;
                else if (alt_tables) slot = S_FLOW_LVL;
                else slot = S_MODEM_ST;
            end
            ADDR_SCRATCH: begin
                if (key_page) slot = S_XOFF2;
                else if (alt_tables) slot = S_TRIG_LVL;
                else slot = S_SCRATCH;
            end
            ADDR_TX_FILL: slot = S_TX_FILL;
            ADDR_RX_FILL: slot = S_RX_FILL;
            ADDR_GPIO_DIR: slot = S_GPIO_DIR;
            ADDR_GPIO_STATE: slot = S_GPIO_STATE;
            ADDR_GPIO_IRQ: slot = S_GPIO_IRQ;
            ADDR_RESERVED: slot = S_NONE;
            ADDR_GPIO_CFG: slot = S_GPIO_CFG;
            ADDR_EXTRA: slot = S_EXTRA;
        endcase
    end

endmodule : ur_slot_decode

`default_nettype wire

/* File: src/ur_regmap.sv */
// UART register map: paged decode, control registers, read mux and
// the access side effects towards the UART core and GPIO pins.
// Assumes the access port and core status run on clk; GPIO pins are async.

`timescale 1ns/1ps
`default_nettype none

module ur_regmap #(
    parameter int GPIO_W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire ur_pkg::ur_req_t req,
    input wire ur_pkg::ur_core_t core,
    input wire logic [GPIO_W-1:0] gpio_in,
    output logic [7:0] rd_data_q,
    output logic rd_valid_q,
    output logic [7:0] tx_data_q,
    output logic tx_push_q,
    output logic rx_pop_q,
    output logic irq_src_read_q,
    output logic modem_state_read_q,
    output logic rx_queue_reset_q,
    output logic tx_queue_reset_q,
    output ur_pkg::ur_cfg_t cfg_q,
    output logic [GPIO_W-1:0] gpio_out_q,
    output logic [GPIO_W-1:0] gpio_oe_q
);
    import ur_pkg::*;

    ur_slot_t slot;
    logic unlock;
    logic [GPIO_W-1:0] gpio_meta_q;
    logic [GPIO_W-1:0] gpio_sync_q;
    logic [7:0] rd_d;
    logic [7:0] gpio_rd;

    // Locked fields are opened only by the enhanced unlock bit
    assign unlock = cfg_q.enh[ENH_UNLOCK_BIT];

    // ------------------------------------------------------------
    // Page decode
    // ------------------------------------------------------------
    // Decoded live from the current line control flop, no pipelining
    ur_slot_decode u_ur_slot_decode (
        .addr(req.addr),
        .line_ctl(cfg_q.line_ctl),
        .enh_unlock(unlock),
        .alt_tables(cfg_q.modem_ctl[MC_ALT_BIT]),
        .slot(slot)
    );

    // Merge write data into a register, keeping locked bits when shut
    function automatic logic [7:0] lock_merge(input logic [7:0] old_v,
                                              input logic [7:0] new_v,
                                              input logic [7:0] mask,
                                              input logic open);
        logic [7:0] keep;
        keep = open ? 8'h00 : mask;
        lock_merge = (old_v & keep) | (new_v & ~keep);
    endfunction : lock_merge

    // ------------------------------------------------------------
    // GPIO input synchroniser
    // ------------------------------------------------------------
    // Pins are asynchronous, two flops before any reader
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gpio_meta_q <= '0;
            gpio_sync_q <= '0;
        end else begin
            gpio_meta_q <= gpio_in;
            gpio_sync_q <= gpio_meta_q;
        end
    end

    // Pin levels padded into a byte
    always_comb begin
        gpio_rd = 8'h00;
        gpio_rd[GPIO_W-1:0] = gpio_sync_q;
    end

    // ------------------------------------------------------------
    // Control register writes
    // ------------------------------------------------------------
    // Writes to read-only and reserved slots fall to the default
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= '0;
        end else if (req.wr) begin
            unique case (slot)
                S_DIV_LO: cfg_q.div_lo <= req.wdata;
                S_DIV_HI: cfg_q.div_hi <= req.wdata;
                S_DIV_FRAC: cfg_q.div_frac <= req.wdata;
                S_IRQ_EN: cfg_q.irq_en <= lock_merge(cfg_q.irq_en,
                    req.wdata, IE_LOCK_MASK, unlock);
                S_IRQ_SRC: cfg_q.queue_ctl <= lock_merge(cfg_q.queue_ctl,
                    req.wdata & QC_STORE_MASK, QC_LOCK_MASK, unlock);
                S_LINE_CTL: cfg_q.line_ctl <= req.wdata;
                S_MODEM_CTL: cfg_q.modem_ctl <= lock_merge(cfg_q.modem_ctl,
                    req.wdata, MC_LOCK_MASK, unlock);
                S_SCRATCH: cfg_q.scratch <= req.wdata;
                S_FLOW_LVL: cfg_q.flow_lvl <= req.wdata;
                S_TRIG_LVL: cfg_q.trig_lvl <= req.wdata;
                S_GPIO_DIR: cfg_q.gpio_dir <= req.wdata;
                S_GPIO_STATE: cfg_q.gpio_out <= req.wdata;
                S_GPIO_IRQ: cfg_q.gpio_irq_en <= req.wdata;
                S_GPIO_CFG: cfg_q.gpio_cfg <= req.wdata;
                S_EXTRA: cfg_q.extra <= req.wdata;
                S_ENH: cfg_q.enh <= req.wdata;
                S_XON1: cfg_q.xon1 <= req.wdata;
                S_XON2: cfg_q.xon2 <= req.wdata;
                S_XOFF1: cfg_q.xoff1 <= req.wdata;
                S_XOFF2: cfg_q.xoff2 <= req.wdata;
                default: cfg_q <= cfg_q;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Write side effects: transmit push and queue resets
    // ------------------------------------------------------------
    // Resets are pulses, never stored, so they self-clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_push_q <= 1'b0;
            tx_data_q <= REG_RST;
            rx_queue_reset_q <= 1'b0;
            tx_queue_reset_q <= 1'b0;
        end else begin
            tx_push_q <= req.wr && (slot == S_HOLD);
            if (req.wr && (slot == S_HOLD)) begin
                tx_data_q <= req.wdata;
            end
            rx_queue_reset_q <= req.wr && (slot == S_IRQ_SRC)
                && req.wdata[QC_RX_RESET_BIT];
            tx_queue_reset_q <= req.wr && (slot == S_IRQ_SRC)
                && req.wdata[QC_TX_RESET_BIT];
        end
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb begin
        rd_d = READ_ZERO;
        unique case (slot)
            S_HOLD: rd_d = core.rx_byte;
            S_DIV_LO: rd_d = cfg_q.div_lo;
            S_DIV_HI: rd_d = cfg_q.div_hi;
            S_DIV_FRAC: rd_d = cfg_q.div_frac;
            S_IRQ_EN: rd_d = unlock ? cfg_q.irq_en
                : (cfg_q.irq_en & ~IE_LOCK_MASK);
            S_IRQ_SRC: rd_d = {{2{cfg_q.queue_ctl[QC_ENABLE_BIT]}},
                unlock ? core.irq_code
                : (core.irq_code & ~IS_LOCK_MASK)};
            S_LINE_CTL: rd_d = cfg_q.line_ctl;
            S_MODEM_CTL: rd_d = unlock ? cfg_q.modem_ctl
                : (cfg_q.modem_ctl & ~MC_LOCK_MASK);
            S_LINE_ST: rd_d = core.line_state;
            S_MODEM_ST: rd_d = core.modem_state;
            S_SCRATCH: rd_d = cfg_q.scratch;
            S_FLOW_LVL: rd_d = cfg_q.flow_lvl;
            S_TRIG_LVL: rd_d = cfg_q.trig_lvl;
            S_TX_FILL: rd_d = {1'b0, core.tx_fill};
            S_RX_FILL: rd_d = {1'b0, core.rx_fill};
            S_GPIO_DIR: rd_d = cfg_q.gpio_dir;
            S_GPIO_STATE: rd_d = gpio_rd;
            S_GPIO_IRQ: rd_d = cfg_q.gpio_irq_en;
            S_GPIO_CFG: rd_d = cfg_q.gpio_cfg;
            S_EXTRA: rd_d = cfg_q.extra;
            S_ENH: rd_d = cfg_q.enh;
            S_XON1: rd_d = cfg_q.xon1;
            S_XON2: rd_d = cfg_q.xon2;
            S_XOFF1: rd_d = cfg_q.xoff1;
            S_XOFF2: rd_d = cfg_q.xoff2;
            default: rd_d = READ_ZERO;
        endcase
    end

    // ------------------------------------------------------------
    // Read answer and read side effects
    // ------------------------------------------------------------
    // Pop and clear pulses go to the core so status updates after the read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_q <= READ_ZERO;
            rd_valid_q <= 1'b0;
            rx_pop_q <= 1'b0;
            irq_src_read_q <= 1'b0;
            modem_state_read_q <= 1'b0;
        end else begin
            rd_valid_q <= req.rd;
            if (req.rd) begin
                rd_data_q <= rd_d;
            end
            rx_pop_q <= req.rd && (slot == S_HOLD);
            irq_src_read_q <= req.rd && (slot == S_IRQ_SRC);
            modem_state_read_q <= req.rd && (slot == S_MODEM_ST);
        end
    end

    // ------------------------------------------------------------
    // GPIO pin drive
    // ------------------------------------------------------------
    // Direction bit set means the pin is an output
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gpio_out_q <= '0;
            gpio_oe_q <= '0;
        end else begin
            gpio_out_q <= cfg_q.gpio_out[GPIO_W-1:0];
            gpio_oe_q <= cfg_q.gpio_dir[GPIO_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_hold_pop;
        @(posedge clk) disable iff (!rst_n)
        (req.rd && !cfg_q.line_ctl[LC_DIV_BIT] && req.addr == ADDR_HOLD)
            |=> rx_pop_q && rd_data_q == $past(core.rx_byte);
    endproperty
    a_hold_pop: assert property (p_hold_pop)
        else $error("rx byte not popped on holding read");

    property p_hold_push;
        @(posedge clk) disable iff (!rst_n)
        (req.wr && !cfg_q.line_ctl[LC_DIV_BIT] && req.addr == ADDR_HOLD)
            |=> tx_push_q && tx_data_q == $past(req.wdata);
    endproperty
    a_hold_push: assert property (p_hold_push)
        else $error("tx byte not pushed on holding write");

    property p_div_lo;
        @(posedge clk) disable iff (!rst_n)
        (req.wr && req.addr == ADDR_HOLD && cfg_q.line_ctl[LC_DIV_BIT]
            && cfg_q.line_ctl != LC_ENH_KEY)
            |=> cfg_q.div_lo == $past(req.wdata) && !tx_push_q;
    endproperty
    a_div_lo: assert property (p_div_lo)
        else $error("divisor low not written");

    property p_frac_gate;
        @(posedge clk) disable iff (!rst_n)
        (req.wr && req.addr == ADDR_IRQ_SRC && !unlock)
            |=> $stable(cfg_q.div_frac);
    endproperty
    a_frac_gate: assert property (p_frac_gate)
        else $error("fractional divisor written while locked");

    property p_isr_read;
        @(posedge clk) disable iff (!rst_n)
        (req.rd && !cfg_q.line_ctl[LC_DIV_BIT] && req.addr == ADDR_IRQ_SRC
            && !unlock)
            |=> rd_data_q[5:4] == 2'b00 && irq_src_read_q
            && rd_data_q[7] == $past(cfg_q.queue_ctl[QC_ENABLE_BIT]);
    endproperty
    a_isr_read: assert property (p_isr_read)
        else $error("interrupt status read wrong");

    property p_queue_reset;
        @(posedge clk) disable iff (!rst_n)
        (req.wr && slot == S_IRQ_SRC && req.wdata[QC_RX_RESET_BIT])
            |=> rx_queue_reset_q ##1 !cfg_q.queue_ctl[QC_RX_RESET_BIT];
    endproperty
    a_queue_reset: assert property (p_queue_reset)
        else $error("rx queue reset pulse missing");

    property p_ier_lock;
        @(posedge clk) disable iff (!rst_n)
        (req.wr && slot == S_IRQ_EN && !unlock)
            |=> cfg_q.irq_en[7:4] == $past(cfg_q.irq_en[7:4]);
    endproperty
    a_ier_lock: assert property (p_ier_lock)
        else $error("locked enable bits changed");

    property p_reserved;
        @(posedge clk) disable iff (!rst_n)
        (req.rd && req.addr == ADDR_RESERVED) |=> rd_data_q == READ_ZERO;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved slot read not zero");

    property p_fill;
        @(posedge clk) disable iff (!rst_n)
        (req.rd && req.addr == ADDR_RX_FILL)
            |=> rd_data_q == {1'b0, $past(core.rx_fill)};
    endproperty
    a_fill: assert property (p_fill)
        else $error("rx fill read wrong");

    property p_enh_page;
        @(posedge clk) disable iff (!rst_n)
        (req.rd && req.addr == ADDR_IRQ_SRC && cfg_q.line_ctl == LC_ENH_KEY)
            |=> rd_data_q == $past(cfg_q.enh) && !irq_src_read_q;
    endproperty
    a_enh_page: assert property (p_enh_page)
        else $error("enhanced function not on key page");

    property p_line_st;
        @(posedge clk) disable iff (!rst_n)
        (req.rd && req.addr == ADDR_LINE_ST && cfg_q.line_ctl != LC_ENH_KEY)
            |=> rd_data_q == $past(core.line_state);
    endproperty
    a_line_st: assert property (p_line_st)
        else $error("line state read wrong");

    property p_queue_pulse;
        @(posedge clk) disable iff (!rst_n)
        (req.wr && req.addr == ADDR_IRQ_SRC && !cfg_q.line_ctl[LC_DIV_BIT])
            |=> tx_queue_reset_q == $past(req.wdata[QC_TX_RESET_BIT])
            && !cfg_q.queue_ctl[QC_TX_RESET_BIT];
    endproperty
    a_queue_pulse: assert property (p_queue_pulse)
        else $error("tx queue reset pulse wrong");

    property p_gpio_dir;
        @(posedge clk) disable iff (!rst_n)
        (req.wr && req.addr == ADDR_GPIO_DIR)
            |=> ##1 gpio_oe_q == $past(req.wdata[GPIO_W-1:0], 2);
    endproperty
    a_gpio_dir: assert property (p_gpio_dir)
        else $error("gpio direction not driven");

    property p_key_xon;
        @(posedge clk) disable iff (!rst_n)
        (req.rd && req.addr == ADDR_MODEM_CTL && cfg_q.line_ctl == LC_ENH_KEY)
            |=> rd_data_q == $past(cfg_q.xon1);
    endproperty
    a_key_xon: assert property (p_key_xon)
        else $error("resume character not on key page");

endmodule : ur_regmap

`default_nettype wire

/* File: verification/ur_host_model.sv */
// Host side of the register port: one-cycle read and write strobes.
// Assumes the bench clock; strobes change on the falling edge only.
`timescale 1ns/1ps
`default_nettype none
module ur_host_model (
    input wire logic clk,
    output ur_pkg::ur_req_t req
);
    import ur_pkg::*;
    initial req = '0;
    // One access, held over one rising edge; idle fields inverted
    task automatic access(input logic r, input logic [3:0] a,
                          input logic [7:0] d);
        @(negedge clk);
        req <= '{rd: r, wr: !r, addr: a, wdata: d};
        @(negedge clk);
        req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask : access
    // Key value opens the enhanced page, zero restores page 0
    task automatic key(input logic on);
        access(1'b0, ADDR_LINE_CTL, on ? LC_ENH_KEY : 8'h00);
    endtask : key
endmodule : ur_host_model
`default_nettype wire

/* File: verification/tb_uart_register_map_decode.sv */
// Self-checking bench for the register map decoder.
// Assumes the host model drives the port; core status is random.
`timescale 1ns/1ps
`default_nettype none
module tb_uart_register_map_decode;
    import ur_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    ur_req_t req;
    ur_core_t core;
    logic [7:0] gpio_in;
    logic [7:0] rd_data_q;
    logic rd_valid_q;
    logic [7:0] tx_data_q;
    logic tx_push_q, rx_pop_q, irq_src_read_q, modem_state_read_q;
    logic rx_queue_reset_q, tx_queue_reset_q;
    ur_cfg_t cfg_q;
    logic [7:0] gpio_out_q, gpio_oe_q;
    int n_errors = 0;
    int compares = 0;
    logic [7:0] expq[$];
    logic [7:0] v;

    always #5 clk = ~clk;

    ur_host_model u_ur_host_model (.clk(clk), .req(req));
    ur_regmap #(.GPIO_W(8)) u_ur_regmap (
        .clk(clk), .rst_n(rst_n), .req(req), .core(core),
        .gpio_in(gpio_in), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
        .tx_data_q(tx_data_q), .tx_push_q(tx_push_q), .rx_pop_q(rx_pop_q),
        .irq_src_read_q(irq_src_read_q),
        .modem_state_read_q(modem_state_read_q),
        .rx_queue_reset_q(rx_queue_reset_q),
        .tx_queue_reset_q(tx_queue_reset_q), .cfg_q(cfg_q),
        .gpio_out_q(gpio_out_q), .gpio_oe_q(gpio_oe_q)
    );

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time,
                     seen, exp);
        end
    endtask : check
    task automatic print_verdict();
        if (n_errors == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : print_verdict
    // Reads note their expectation before the strobe goes out
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        expq.push_back(e);
        u_ur_host_model.access(1'b1, a, 8'h00);
    endtask : rd
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        u_ur_host_model.access(1'b0, a, d);
    endtask : wr

    // Oldest note taken off whenever read data appears
    always @(negedge clk) begin
        if (rd_valid_q === 1'b1) begin
            if (expq.size() > 0)
                check(rd_data_q, expq.pop_front());
            else
                check(rd_data_q, 8'hXX);
        end
    end

    // Whole run is about 120 cycles; generous cut-off
    initial begin
        #50000;
        n_errors++;
        print_verdict();
    end

    initial begin
        void'($urandom(32'hF0D41D35));
        core = 44'({$urandom(), $urandom()});
        gpio_in = 8'($urandom());
        v = 8'($urandom());
        repeat (10) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        wr(4'h7, v);
        rd(4'h7, v);
        wr(4'h3, 8'h80);
        rd(4'h3, 8'h80);
        wr(4'h0, v);
        check(8'(tx_push_q), 8'h00);
        wr(4'h1, ~v);
        rd(4'h0, v);
        rd(4'h1, ~v);
        rd(4'h2, 8'h00);
        u_ur_host_model.key(1'b1);
        wr(4'h2, 8'h10);
        for (int i = 4; i < 8; i++) wr(4'(i), v + 8'(i));
        for (int i = 4; i < 8; i++) rd(4'(i), v + 8'(i));
        rd(4'h2, 8'h10);
        rd(4'h0, 8'h00);
        u_ur_host_model.key(1'b0);
        wr(4'h1, 8'hFF);
        rd(4'h1, 8'hFF);
        wr(4'h2, 8'h07);
        check(8'({rx_queue_reset_q, tx_queue_reset_q}), 8'h03);
        check(cfg_q.queue_ctl, 8'h01);
        rd(4'h2, {2'b11, core.irq_code});
        check(8'(irq_src_read_q), 8'h01);
        rd(4'h0, core.rx_byte);
        check(8'(rx_pop_q), 8'h01);
        wr(4'h0, ~v);
        check(8'(tx_push_q), 8'h01);
        check(tx_data_q, ~v);
        wr(4'h3, 8'h80);
        wr(4'h2, 8'h5A);
        rd(4'h2, 8'h5A);
        u_ur_host_model.key(1'b1);
        wr(4'h2, 8'h00);
        u_ur_host_model.key(1'b0);
        rd(4'h1, 8'h0F);
        rd(4'h2, {2'b11, core.irq_code & 6'h0F});
        rd(4'h5, core.line_state);
        rd(4'h6, core.modem_state);
        check(8'(modem_state_read_q), 8'h01);
        rd(4'h8, {1'b0, core.tx_fill});
        rd(4'h9, {1'b0, core.rx_fill});
        wr(4'hD, 8'hFF);
        rd(4'hD, 8'h00);
        wr(4'hF, ~v);
        rd(4'hF, ~v);
        wr(4'hA, v);
        rd(4'hA, v);
        check(gpio_oe_q, v);
        wr(4'hB, ~v);
        rd(4'hB, gpio_in);
        check(gpio_out_q, ~v);
        wr(4'h4, 8'h04);
        wr(4'h6, v);
        rd(4'h6, v);
        wr(4'h7, ~v);
        rd(4'h7, ~v);
        repeat (4) @(negedge clk);
        check(8'(expq.size()), 8'h00);
        print_verdict();
    end
endmodule : tb_uart_register_map_decode
`default_nettype wire
